/* rtl/lesr_pkg.sv */
// package of constants and carriers for the link event status register block
// Function
// - attention flag set on unrecoverable error
// - attention flag set on significant host event
// - attention raise loads reason code register
// - transmit acknowledged flag on far-end acknowledgement
// - message received needs validity and sequence match
// - message received only if receive memory ready
// - payload written to memory before flag
// - sequence counter incremented, ack queued first
// - ack carried in next transmitted unit
// - reason register eight bits holds cause code
package lesr_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] LESR_OFF_STATUS = 8'h00;
  localparam logic [7:0] LESR_OFF_REASON = 8'h04;
  localparam logic [7:0] LESR_OFF_CTRL = 8'h08;
  localparam logic [7:0] LESR_OFF_BSN = 8'h0C;
  localparam int LESR_BIT_ATTENTION_FLAG = 5;
  localparam int LESR_BIT_XMA = 6;
  localparam int LESR_BIT_MESSAGE_RECEIVED_FLAG = 7;
  localparam int LESR_CTRL_RXRDY = 0;
  localparam logic [7:0] LESR_STATUS_RST = 8'h00;
  localparam logic [7:0] LESR_REASON_RST = 8'h00;
  localparam logic [6:0] LESR_BSN_RST = 7'h7F;
  localparam logic [1:0] LESR_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] LESR_HSIZE_WORD = 3'h2;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic valid;   // unit passed minimum checks
    logic [6:0] fsn;
  } lesr_rxmsu_s;

  typedef struct packed {
    logic attnErr;
    logic attnEvent;
    logic [7:0] code;
  } lesr_attention_flag_s;
endpackage : lesr_pkg

/* rtl/lesr_rx_seq.sv */
// receive sequence checker and payload store sequencing
`timescale 1ns/1ps
`default_nettype none
module lesr_rx_seq (
  input wire logic clk,
  input wire logic rst_n,
  input wire lesr_pkg::lesr_rxmsu_s rxMsu,
  input wire logic rxReady,
  input wire logic storeDone,
  input wire logic txSuStart,
  output logic storeReq,
  output logic msuEvent,
  output logic [6:0] bsnCount,
  output logic ackPending
);
  import lesr_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [2:0] {
    LESR_IDLE = 3'b001,
    LESR_STORE = 3'b010,
    LESR_DONE = 3'b100
  } lesr_state_e;

  lesr_state_e state_q, state_d;
  logic [6:0] bsn_q, bsn_d;
  logic ack_q, ack_d;
  logic store_q, store_d;
  logic evt_q, evt_d;

  // next state
  always_comb begin
    state_d = state_q;
    bsn_d = bsn_q;
    ack_d = ack_q;
    store_d = 1'b0;
    evt_d = 1'b0;
    if (txSuStart) begin
      ack_d = 1'b0;
    end
    case (state_q)
      LESR_IDLE: begin
        if (rxMsu.valid && rxReady && rxMsu.fsn == 7'(bsn_q + 7'h01)) begin
          store_d = 1'b1;
          state_d = LESR_STORE;
        end
      end
      LESR_STORE: begin
        if (storeDone) begin
          state_d = LESR_DONE;
        end
      end
      LESR_DONE: begin
        bsn_d = 7'(bsn_q + 7'h01);
        ack_d = 1'b1;
        evt_d = 1'b1;
        state_d = LESR_IDLE;
      end
      default: state_d = LESR_IDLE;
    endcase
  end

  // registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= LESR_IDLE;
      bsn_q <= LESR_BSN_RST;
      ack_q <= 1'b0;
      store_q <= 1'b0;
      evt_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bsn_q <= bsn_d;
      ack_q <= ack_d;
      store_q <= store_d;
      evt_q <= evt_d;
    end
  end

  assign storeReq = store_q;
  assign msuEvent = evt_q; // same cycle as counter/ack update
  assign bsnCount = bsn_q;
  assign ackPending = ack_q;
endmodule : lesr_rx_seq
`default_nettype wire

/* rtl/lesr_top.sv */
// link event status register with ahb-lite slave
//
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module lesr_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire lesr_pkg::lesr_attention_flag_s attnIn,
  input wire logic xmitAck,
  input wire lesr_pkg::lesr_rxmsu_s rxMsu,
  input wire logic storeDone,
  input wire logic txSuStart,
  output logic storeReq,
  output logic ackPending,
  output logic [6:0] bsnCount,
  output logic attentionFlag
);
  import lesr_pkg::*;

  // ****************************************
  // bus address phase
  // ****************************************
  logic wrEn_q, wrEn_d, rdEn_q, rdEn_d;
  logic [7:0] addr_q, addr_d;
  logic [7:0] status_q, status_d;
  logic [7:0] reason_q, reason_d;
  logic rxReady_q, rxReady_d;
  logic [31:0] rdata_q, rdata_d;
  logic msuEvent;
  logic attnRaise;

  lesr_rx_seq u_rx (
    .clk(clk),
    .rst_n(rst_n),
    .rxMsu(rxMsu),
    .rxReady(rxReady_q),
    .storeDone(storeDone),
    .txSuStart(txSuStart),
    .storeReq(storeReq),
    .msuEvent(msuEvent),
    .bsnCount(bsnCount),
    .ackPending(ackPending)
  );

  // capture address phase and event updates
  always_comb begin
    logic take;
    take = hsel && hready && htrans == LESR_HTRANS_NONSEQ;
    wrEn_d = take && hwrite;
    rdEn_d = take && !hwrite;
    addr_d = take ? haddr : addr_q;
    rdata_d = rdata_q;
    if (take && !hwrite) begin
      case (haddr)
        LESR_OFF_STATUS: rdata_d = {24'h000000, status_q};
        LESR_OFF_REASON: rdata_d = {24'h000000, reason_q};
        LESR_OFF_CTRL: rdata_d = {31'h00000000, rxReady_q};
        LESR_OFF_BSN: rdata_d = {25'h0000000, bsnCount};
        default: rdata_d = 32'h00000000;
      endcase
    end
    // ctrl write arms receive memory
    rxReady_d = rxReady_q;
    if (wrEn_q && addr_q == LESR_OFF_CTRL) begin
      rxReady_d = hwdata[LESR_CTRL_RXRDY];
    end
    // status write-one clears; a set in the same cycle wins
    status_d = status_q;
    if (wrEn_q && addr_q == LESR_OFF_STATUS) begin
      status_d = status_q & ~hwdata[7:0];
    end
    attnRaise = attnIn.attnErr || attnIn.attnEvent;
    if (attnRaise) begin
      status_d[LESR_BIT_ATTENTION_FLAG] = 1'b1;
    end
    if (xmitAck) begin
      status_d[LESR_BIT_XMA] = 1'b1;
    end
    if (msuEvent) begin
      status_d[LESR_BIT_MESSAGE_RECEIVED_FLAG] = 1'b1;
    end
    status_d[4:0] = 5'h00;
    reason_d = attnRaise ? attnIn.code : reason_q;
  end

  // registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrEn_q <= 1'b0;
      rdEn_q <= 1'b0;
      addr_q <= 8'h00;
      rdata_q <= 32'h00000000;
      status_q <= LESR_STATUS_RST;
      reason_q <= LESR_REASON_RST;
      rxReady_q <= 1'b0;
    end else begin
      wrEn_q <= wrEn_d;
      rdEn_q <= rdEn_d;
      addr_q <= addr_d;
      rdata_q <= rdata_d;
      status_q <= status_d;
      reason_q <= reason_d;
      rxReady_q <= rxReady_d;
    end
  end

  // zero wait state, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign attentionFlag = status_q[LESR_BIT_ATTENTION_FLAG];
endmodule : lesr_top
`default_nettype wire

/* sim/lesr_props.sv */
// port assertions for the link event status register
`timescale 1ns/1ps
`default_nettype none
module lesr_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire lesr_pkg::lesr_attention_flag_s attnIn,
  input wire lesr_pkg::lesr_rxmsu_s rxMsu,
  input wire logic storeDone,
  input wire logic txSuStart,
  input wire logic storeReq,
  input wire logic ackPending,
  input wire logic [6:0] bsnCount,
  input wire logic attentionFlag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  attention_flag_err_a: assert property (attnIn.attnErr |=> attentionFlag)
    else $error("attention_flag err");
  attention_flag_event_a: assert property (attnIn.attnEvent |=> attentionFlag)
    else $error("attention_flag event");
  fsn_match_a: assert property (rxMsu.valid && rxMsu.fsn != bsnCount + 7'h01 |=> !storeReq)
    else $error("fsn");
  store_first_a: assert property ($rose(ackPending) |-> $past(storeDone, 2))
    else $error("order");
  bsn_step_a: assert property (storeDone |-> ##2 bsnCount == 7'($past(bsnCount, 2) + 7'h01))
    else $error("bsn step");
  bsn_hold_a: assert property (!$past(storeDone) |=> $stable(bsnCount))
    else $error("bsn hold");
  ack_queue_a: assert property (storeDone |-> ##2 ackPending)
    else $error("ack");
  ack_clear_a: assert property (txSuStart && !$past(storeDone) |=> !ackPending)
    else $error("ack clr");
  cover property (storeReq);
  cover property ($rose(ackPending));
  cover property (attnIn.attnEvent);
endmodule : lesr_props
`default_nettype wire

/* sim/lesr_store_model.sv */
// memory side: ends each payload write after a lag
`timescale 1ns/1ps
`default_nettype none
module lesr_store_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic storeReq,
  input wire logic [1:0] lag,
  output logic storeDone
);
  // one-cycle completion pulse per request
  always @(posedge clk) begin
    storeDone <= 1'b0;
    if (rst_n && storeReq) begin
      repeat (lag) @(posedge clk);
      storeDone <= 1'b1;
    end
  end
endmodule : lesr_store_model
`default_nettype wire

/* sim/lesr_top_tb.sv */
// self-checking bench for the link event status register
`timescale 1ns/1ps
`default_nettype none
module lesr_top_tb;
  import lesr_pkg::*;
  logic clk, rst_n, hsel, hwrite, hreadyout, hresp, xmitAck, storeDone, txSuStart, storeReq, ackPending, attnF;
  logic [7:0] haddr, c;
  logic [1:0] htrans, lag;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, r;
  logic [6:0] bsnCount, e, f;
  lesr_attention_flag_s attnIn;
  lesr_rxmsu_s rxMsu;
  int errors, check_count, seed, i, n;
  bit good;
  lesr_top u_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .attnIn(attnIn), .xmitAck(xmitAck), .rxMsu(rxMsu), .storeDone(storeDone), .txSuStart(txSuStart),
    .storeReq(storeReq), .ackPending(ackPending), .bsnCount(bsnCount), .attentionFlag(attnF));
  lesr_store_model u_mem (.clk(clk), .rst_n(rst_n), .storeReq(storeReq), .lag(lag), .storeDone(storeDone));
  always #5 clk = ~clk;
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      errors++;
      $display("unexpected at %0t saw %h", $time, s);
    end
  endtask : chk
  // bounded wait for hready
  task hwait;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (n >= 40) begin
      errors++;
      complete_run();
    end
  endtask : hwait
  // one ahb-lite single word transfer
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= LESR_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    hwait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
    r = hrdata;
  endtask : bus
  task tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick
  initial begin
    {clk, rst_n, hsel, hwrite, xmitAck, txSuStart, haddr, htrans, hwdata, lag} = '0;
    hsize = LESR_HSIZE_WORD;
    attnIn = '0;
    rxMsu = '0;
    seed = 89;
    e = LESR_BSN_RST;
    tick(4);
    rst_n <= 1'b1;
    bus(0, LESR_OFF_BSN, 0);
    chk(r, {25'h0, e});
    bus(0, 8'h10, 0);
    chk(r, 32'h0);
    for (i = 0; i < 2; i++) begin
      c = 8'($random(seed));
      tick(1);
      attnIn <= {i == 0, i == 1, c};
      tick(1);
      attnIn <= '0;
      bus(0, LESR_OFF_STATUS, 0);
      chk(r & 32'hE0, 32'h20);
      chk({31'h0, attnF}, 32'h1);
      bus(0, LESR_OFF_REASON, 0);
      chk(r, {24'h0, c});
      bus(1, LESR_OFF_STATUS, 32'h20);
    end
    tick(1);
    xmitAck <= 1'b1;
    tick(1);
    xmitAck <= 1'b0;
    bus(0, LESR_OFF_STATUS, 0);
    chk(r & 32'hE0, 32'h40);
    bus(1, LESR_OFF_STATUS, 32'h40);
    $display("status tests done");
    for (i = 0; i < 12; i++) begin
      if (i == 2) bus(1, LESR_OFF_CTRL, 32'h1);
      f = (i < 3 || $random(seed) % 2 == 0) ? e + 7'h01 : 7'($random(seed));
      good = i >= 2 && f == e + 7'h01;
      lag <= 2'($random(seed));
      rxMsu <= {1'b1, f};
      tick(1);
      rxMsu <= '0;
      tick(10);
      if (good) e = e + 7'h01;
      bus(0, LESR_OFF_BSN, 0);
      chk(r, {25'h0, e});
      bus(0, LESR_OFF_STATUS, 0);
      chk(r & 32'hE0, good ? 32'h80 : 32'h0);
      bus(1, LESR_OFF_STATUS, 32'h80);
      txSuStart <= 1'b1;
      tick(1);
      txSuStart <= 1'b0;
      tick(1);
      chk({31'h0, ackPending}, 32'h0);
    end
    $display("receive tests done");
    complete_run();
  end
endmodule : lesr_top_tb
bind lesr_top lesr_props u_props (.clk(clk), .rst_n(rst_n), .attnIn(attnIn), .rxMsu(rxMsu),
  .storeDone(storeDone), .txSuStart(txSuStart), .storeReq(storeReq), .ackPending(ackPending),
  .bsnCount(bsnCount), .attentionFlag(attentionFlag));
`default_nettype wire
